// file: rtl/mrid_cfg.svh
// constants for the 14-bit instruction decoder and executor
// assumes one core clock; file space is seven address bits
`ifndef MRID_CFG_SVH
`define MRID_CFG_SVH
`define MRID_ADDR_TIMER_ZERO 7'h01
`define MRID_ADDR_STATUS  7'h03
`define MRID_ADDR_PORTA   7'h05
`define MRID_ADDR_PORTC   7'h07
`define MRID_ST_C         0
`define MRID_ST_DIGIT_CARRY 1
`define MRID_ST_Z         2
`define MRID_ST_POWERDOWN 3
`define MRID_ST_TIMEOUT   4
`define MRID_PC_W         13
`define MRID_PC_RESET     13'h0000
`define MRID_W_RESET      8'h00
`define MRID_ST_RESET     8'h18
`define MRID_IRQ_VECTOR   13'h0004
`define MRID_STACK_DEPTH  8
`endif

// file: rtl/mrid_pkg.sv
// types shared by the decoder and its alu
// assumes mrid_cfg.svh constants
`default_nettype none
package mrid_pkg;
    typedef enum logic [4:0] {
        MRID_NO_OPERATION, MRID_ADD_WREG_TO_FILE, MRID_SUB_WREG_FROM_FILE,
        MRID_AND_WREG_WITH_FILE, MRID_OR_WREG_WITH_FILE, MRID_XOR_WREG_WITH_FILE,
        MRID_COMPLEMENT_FILE_REG, MRID_CLEAR_FILE_REG, MRID_CLEAR_WORK_REG,
        MRID_DECREMENT_FILE_REG, MRID_INCREMENT_FILE_REG, MRID_DECREMENT_SKIP_ZERO,
        MRID_INCREMENT_SKIP_ZERO, MRID_MOVE_FILE_REG, MRID_STORE_WREG_TO_FILE,
        MRID_ROTATE_LEFT_CARRY, MRID_ROTATE_RIGHT_CARRY, MRID_SWAP_FILE_NIBBLES,
        MRID_BIT_CLEAR_FILE, MRID_BIT_SET_FILE, MRID_TEST_SKIP_IF_CLEAR,
        MRID_TEST_SKIP_IF_SET, MRID_ADD_LITERAL_TO_WREG, MRID_SUB_WREG_FROM_LITERAL,
        MRID_AND_LITERAL_WITH_WREG, MRID_OR_LITERAL_WITH_WREG, MRID_LOAD_LITERAL_WREG,
        MRID_CALL, MRID_JUMP_ABSOLUTE, MRID_RETURN, MRID_RETURN_FROM_IRQ,
        MRID_RETURN_WITH_LITERAL
    } mrid_op_t;
    typedef enum logic [1:0] {
        MRID_SYS_NONE, MRID_SYS_WDT, MRID_SYS_SLEEP
    } mrid_sys_t;
endpackage
`default_nettype wire

// file: rtl/mrid_alu_if.sv
// carrier between the decoder and its alu
// assumes one clock domain, purely combinational traffic
`default_nettype none
interface mrid_alu_if;
    mrid_pkg::mrid_op_t op;
    logic [7:0]         a;
    logic [7:0]         w;
    logic [2:0]         bsel;
    logic               c_in;
    logic [7:0]         res;
    logic               c_out;
    logic               dc_out;
    logic               z_out;
    modport core (output op, a, w, bsel, c_in, input res, c_out, dc_out, z_out);
    modport alu  (input op, a, w, bsel, c_in, output res, c_out, dc_out, z_out);
endinterface
`default_nettype wire

// file: rtl/mrid_alu.sv
// arithmetic and logic unit of the decoder
// assumes operands settle within one core clock
`default_nettype none
module mrid_alu (
    mrid_alu_if.alu u
);
    logic [8:0] sum_add;
    logic [8:0] sum_sub;
    logic [4:0] nib_add;
    logic [4:0] nib_sub;
    logic [7:0] bmask;
    // ========================================
    // arithmetic
    // subtraction as a + ~w + 1 so carry means no borrow
    assign sum_add = {1'b0, u.a} + {1'b0, u.w};
    assign sum_sub = {1'b0, u.a} + {1'b0, ~u.w} + 9'h001;
    assign nib_add = {1'b0, u.a[3:0]} + {1'b0, u.w[3:0]};
    assign nib_sub = {1'b0, u.a[3:0]} + {1'b0, ~u.w[3:0]} + 5'h01;
    assign bmask   = 8'h01 << u.bsel;
    always_comb begin
        u.res    = u.a;
        u.c_out  = u.c_in;
        u.dc_out = 1'b0;
        case (u.op)
            mrid_pkg::MRID_ADD_WREG_TO_FILE,
            mrid_pkg::MRID_ADD_LITERAL_TO_WREG: begin
                u.res    = sum_add[7:0];
                u.c_out  = sum_add[8];
                u.dc_out = nib_add[4];
            end
            mrid_pkg::MRID_SUB_WREG_FROM_FILE,
            mrid_pkg::MRID_SUB_WREG_FROM_LITERAL: begin
                u.res    = sum_sub[7:0];
                u.c_out  = sum_sub[8];
                u.dc_out = nib_sub[4];
            end
            mrid_pkg::MRID_AND_WREG_WITH_FILE,
            mrid_pkg::MRID_AND_LITERAL_WITH_WREG: u.res = u.a & u.w;
            mrid_pkg::MRID_OR_WREG_WITH_FILE,
            mrid_pkg::MRID_OR_LITERAL_WITH_WREG: u.res = u.a | u.w;
            mrid_pkg::MRID_XOR_WREG_WITH_FILE: u.res = u.a ^ u.w;
            mrid_pkg::MRID_COMPLEMENT_FILE_REG: u.res = ~u.a;
            mrid_pkg::MRID_CLEAR_FILE_REG,
            mrid_pkg::MRID_CLEAR_WORK_REG: u.res = 8'h00;
            mrid_pkg::MRID_DECREMENT_FILE_REG,
            mrid_pkg::MRID_DECREMENT_SKIP_ZERO: u.res = u.a - 8'h01;
            mrid_pkg::MRID_INCREMENT_FILE_REG,
            mrid_pkg::MRID_INCREMENT_SKIP_ZERO: u.res = u.a + 8'h01;
            mrid_pkg::MRID_STORE_WREG_TO_FILE: u.res = u.w;
            mrid_pkg::MRID_LOAD_LITERAL_WREG,
            mrid_pkg::MRID_RETURN_WITH_LITERAL: u.res = u.w;
            mrid_pkg::MRID_ROTATE_LEFT_CARRY: begin
                u.res   = {u.a[6:0], u.c_in};
                u.c_out = u.a[7];
            end
            mrid_pkg::MRID_ROTATE_RIGHT_CARRY: begin
                u.res   = {u.c_in, u.a[7:1]};
                u.c_out = u.a[0];
            end
            mrid_pkg::MRID_SWAP_FILE_NIBBLES: u.res = {u.a[3:0], u.a[7:4]};
            mrid_pkg::MRID_BIT_CLEAR_FILE: u.res = u.a & ~bmask;
            mrid_pkg::MRID_BIT_SET_FILE:   u.res = u.a | bmask;
            default: u.res = u.a;
        endcase
        u.z_out = (u.res == 8'h00);
    end
endmodule
`default_nettype wire

// file: rtl/mrid_core.sv
// instruction decoder and executor of an 8-bit core with 14-bit words
// assumes program memory answers combinationally to o_pc and the file
// space reads combinationally on o_file_addr; port pins arrive raw
`include "mrid_cfg.svh"
`default_nettype none
module mrid_core #(
    parameter int STACK_DEPTH = `MRID_STACK_DEPTH
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_reset_n,
    input  wire logic [13:0]             i_insn,
    input  wire logic [7:0]              i_file_rdata,
    input  wire logic [7:0]              i_porta_pins,
    input  wire logic [7:0]              i_portc_pins,
    input  wire logic                    i_psa_to_timer0,
    input  wire logic [1:0]              i_pclath_hi,
    output logic      [`MRID_PC_W-1:0]   o_pc,
    output logic      [6:0]              o_file_addr,
    output logic                         o_file_we,
    output logic      [7:0]              o_file_wdata,
    output logic      [7:0]              o_wreg,
    output logic      [7:0]              o_status,
    output logic                         o_prescaler_clr,
    output logic                         o_watchdog_clr,
    output logic                         o_sleep,
    output logic                         o_gie_set
);
    // ========================================
    // state
    typedef enum logic {MRID_EXEC, MRID_FLUSH} mrid_state_t;
    mrid_state_t         state;
    mrid_state_t         next_state;
    logic [`MRID_PC_W-1:0] pc;
    logic [`MRID_PC_W-1:0] next_pc;
    logic [7:0]          wreg;
    logic [7:0]          status;
    logic [7:0]          next_status;
    logic [7:0]          porta_s1;
    logic [7:0]          porta_s2;
    logic [7:0]          portc_s1;
    logic [7:0]          portc_s2;
    logic [`MRID_PC_W-1:0] stack [STACK_DEPTH];
    logic [$clog2(STACK_DEPTH)-1:0] sp;
    logic                wdt_pulse;
    logic                sleep_pulse;
    logic                pre_pulse;
    mrid_alu_if          alu_bus();

    // ========================================
    // decode
    mrid_pkg::mrid_op_t  op;
    mrid_pkg::mrid_sys_t sysop;
    wire                 dest    = i_insn[7];
    wire [6:0]           faddr   = i_insn[6:0];
    wire [7:0]           literal = i_insn[7:0];
    wire                 executing = (state == MRID_EXEC);

    function automatic mrid_pkg::mrid_op_t decode(input logic [13:0] ins);
        mrid_pkg::mrid_op_t d;
        d = mrid_pkg::MRID_NO_OPERATION;
        case (ins[13:12])
            2'b00: begin
                case (ins[11:8])
                    4'b0111: d = mrid_pkg::MRID_ADD_WREG_TO_FILE;
                    4'b0010: d = mrid_pkg::MRID_SUB_WREG_FROM_FILE;
                    4'b0101: d = mrid_pkg::MRID_AND_WREG_WITH_FILE;
                    4'b0100: d = mrid_pkg::MRID_OR_WREG_WITH_FILE;
                    4'b0110: d = mrid_pkg::MRID_XOR_WREG_WITH_FILE;
                    4'b1001: d = mrid_pkg::MRID_COMPLEMENT_FILE_REG;
                    4'b0001: d = ins[7] ? mrid_pkg::MRID_CLEAR_FILE_REG :
                                          mrid_pkg::MRID_CLEAR_WORK_REG;
                    4'b0011: d = mrid_pkg::MRID_DECREMENT_FILE_REG;
                    4'b1010: d = mrid_pkg::MRID_INCREMENT_FILE_REG;
                    4'b1011: d = mrid_pkg::MRID_DECREMENT_SKIP_ZERO;
                    4'b1111: d = mrid_pkg::MRID_INCREMENT_SKIP_ZERO;
                    4'b1000: d = mrid_pkg::MRID_MOVE_FILE_REG;
                    4'b1101: d = mrid_pkg::MRID_ROTATE_LEFT_CARRY;
                    4'b1100: d = mrid_pkg::MRID_ROTATE_RIGHT_CARRY;
                    4'b1110: d = mrid_pkg::MRID_SWAP_FILE_NIBBLES;
                    default: begin
                        if (ins[7])
                            d = mrid_pkg::MRID_STORE_WREG_TO_FILE;
                        else if (ins[6:0] == 7'h08)
                            d = mrid_pkg::MRID_RETURN;
                        else if (ins[6:0] == 7'h09)
                            d = mrid_pkg::MRID_RETURN_FROM_IRQ;
                        else
                            d = mrid_pkg::MRID_NO_OPERATION;
                    end
                endcase
            end
            2'b01: begin
                case (ins[11:10])
                    2'b00:   d = mrid_pkg::MRID_BIT_CLEAR_FILE;
                    2'b01:   d = mrid_pkg::MRID_BIT_SET_FILE;
                    2'b10:   d = mrid_pkg::MRID_TEST_SKIP_IF_CLEAR;
                    default: d = mrid_pkg::MRID_TEST_SKIP_IF_SET;
                endcase
            end
            2'b10: d = ins[11] ? mrid_pkg::MRID_JUMP_ABSOLUTE : mrid_pkg::MRID_CALL;
            default: begin
                if (ins[11:9] == 3'b111)
                    d = mrid_pkg::MRID_ADD_LITERAL_TO_WREG;
                else if (ins[11:9] == 3'b110)
                    d = mrid_pkg::MRID_SUB_WREG_FROM_LITERAL;
                else if (ins[11:8] == 4'b1001)
                    d = mrid_pkg::MRID_AND_LITERAL_WITH_WREG;
                else if (ins[11:8] == 4'b1000)
                    d = mrid_pkg::MRID_OR_LITERAL_WITH_WREG;
                else if (ins[11:10] == 2'b01)
                    d = mrid_pkg::MRID_RETURN_WITH_LITERAL;
                else if (ins[11:10] == 2'b00)
                    d = mrid_pkg::MRID_LOAD_LITERAL_WREG;
                else
                    d = mrid_pkg::MRID_NO_OPERATION; // unlisted 1010/1011 treated as nop
            end
        endcase
        return d;
    endfunction

    assign op = executing ? decode(i_insn) : mrid_pkg::MRID_NO_OPERATION;
    assign sysop = !executing ? mrid_pkg::MRID_SYS_NONE :
                   (i_insn == 14'h0064) ? mrid_pkg::MRID_SYS_WDT :
                   (i_insn == 14'h0063) ? mrid_pkg::MRID_SYS_SLEEP :
                   mrid_pkg::MRID_SYS_NONE;

    // ========================================
    // operand fetch and classes
    wire is_lit  = (i_insn[13:12] == 2'b11);
    wire is_bit  = (i_insn[13:12] == 2'b01);
    wire is_byte = (i_insn[13:12] == 2'b00);
    // pins pass two flops; write-back of a port uses what the pins show
    wire [7:0] file_src = (faddr == `MRID_ADDR_PORTA) ? porta_s2 :
                          (faddr == `MRID_ADDR_PORTC) ? portc_s2 :
                          (faddr == `MRID_ADDR_STATUS) ? status : i_file_rdata;
    assign alu_bus.op   = op;
    assign alu_bus.a    = is_lit ? literal : file_src;
    assign alu_bus.w    = (op == mrid_pkg::MRID_LOAD_LITERAL_WREG ||
                           op == mrid_pkg::MRID_RETURN_WITH_LITERAL) ? literal : wreg;
    assign alu_bus.bsel = i_insn[9:7];
    assign alu_bus.c_in = status[`MRID_ST_C];
    mrid_alu u_alu (.u(alu_bus));

    wire sets_cdz = op inside {mrid_pkg::MRID_ADD_WREG_TO_FILE,
                    mrid_pkg::MRID_SUB_WREG_FROM_FILE, mrid_pkg::MRID_ADD_LITERAL_TO_WREG,
                    mrid_pkg::MRID_SUB_WREG_FROM_LITERAL};
    wire sets_z   = sets_cdz || op inside {mrid_pkg::MRID_AND_WREG_WITH_FILE,
                    mrid_pkg::MRID_OR_WREG_WITH_FILE, mrid_pkg::MRID_XOR_WREG_WITH_FILE,
                    mrid_pkg::MRID_COMPLEMENT_FILE_REG, mrid_pkg::MRID_CLEAR_FILE_REG,
                    mrid_pkg::MRID_CLEAR_WORK_REG, mrid_pkg::MRID_DECREMENT_FILE_REG,
                    mrid_pkg::MRID_INCREMENT_FILE_REG, mrid_pkg::MRID_MOVE_FILE_REG,
                    mrid_pkg::MRID_AND_LITERAL_WITH_WREG, mrid_pkg::MRID_OR_LITERAL_WITH_WREG};
    wire sets_c   = sets_cdz || op inside {mrid_pkg::MRID_ROTATE_LEFT_CARRY,
                    mrid_pkg::MRID_ROTATE_RIGHT_CARRY};
    wire dest_opt = is_byte && op inside {mrid_pkg::MRID_ADD_WREG_TO_FILE,
                    mrid_pkg::MRID_SUB_WREG_FROM_FILE, mrid_pkg::MRID_AND_WREG_WITH_FILE,
                    mrid_pkg::MRID_OR_WREG_WITH_FILE, mrid_pkg::MRID_XOR_WREG_WITH_FILE,
                    mrid_pkg::MRID_COMPLEMENT_FILE_REG, mrid_pkg::MRID_DECREMENT_FILE_REG,
                    mrid_pkg::MRID_INCREMENT_FILE_REG, mrid_pkg::MRID_DECREMENT_SKIP_ZERO,
                    mrid_pkg::MRID_INCREMENT_SKIP_ZERO, mrid_pkg::MRID_MOVE_FILE_REG,
                    mrid_pkg::MRID_ROTATE_LEFT_CARRY, mrid_pkg::MRID_ROTATE_RIGHT_CARRY,
                    mrid_pkg::MRID_SWAP_FILE_NIBBLES};
    wire wr_file  = (dest_opt && dest) || op inside {mrid_pkg::MRID_CLEAR_FILE_REG,
                    mrid_pkg::MRID_STORE_WREG_TO_FILE, mrid_pkg::MRID_BIT_CLEAR_FILE,
                    mrid_pkg::MRID_BIT_SET_FILE};
    wire wr_w     = (dest_opt && !dest) || op == mrid_pkg::MRID_CLEAR_WORK_REG ||
                    (is_lit && op != mrid_pkg::MRID_NO_OPERATION);
    wire bit_val  = file_src[i_insn[9:7]];
    wire skip     = (op inside {mrid_pkg::MRID_DECREMENT_SKIP_ZERO,
                                mrid_pkg::MRID_INCREMENT_SKIP_ZERO} && alu_bus.z_out) ||
                    (op == mrid_pkg::MRID_TEST_SKIP_IF_CLEAR && !bit_val) ||
                    (op == mrid_pkg::MRID_TEST_SKIP_IF_SET && bit_val);
    wire is_jump  = op inside {mrid_pkg::MRID_CALL, mrid_pkg::MRID_JUMP_ABSOLUTE};
    wire is_ret   = op inside {mrid_pkg::MRID_RETURN, mrid_pkg::MRID_RETURN_FROM_IRQ,
                               mrid_pkg::MRID_RETURN_WITH_LITERAL};
    wire [`MRID_PC_W-1:0] jump_tgt = {i_pclath_hi, i_insn[10:0]};
    wire [`MRID_PC_W-1:0] pc_inc   = pc + 13'h0001;
    wire [`MRID_PC_W-1:0] pc_two   = pc + 13'h0002;
    wire [$clog2(STACK_DEPTH)-1:0] sp_top = sp - 1'b1;

    // ========================================
    // next state
    always_comb begin
        next_status = status;
        if (sets_z)
            next_status[`MRID_ST_Z] = alu_bus.z_out;
        if (sets_c)
            next_status[`MRID_ST_C] = alu_bus.c_out;
        if (sets_cdz)
            next_status[`MRID_ST_DIGIT_CARRY] = alu_bus.dc_out;
        if (sysop == mrid_pkg::MRID_SYS_WDT) begin
            next_status[`MRID_ST_TIMEOUT]   = 1'b1;
            next_status[`MRID_ST_POWERDOWN] = 1'b1;
        end else if (sysop == mrid_pkg::MRID_SYS_SLEEP) begin
            next_status[`MRID_ST_TIMEOUT]   = 1'b1;
            next_status[`MRID_ST_POWERDOWN] = 1'b0;
        end
        // a direct status write keeps hardware flag updates out of the way
        if (wr_file && faddr == `MRID_ADDR_STATUS)
            next_status = {alu_bus.res[7:5], status[4:3], alu_bus.res[2:0]};
    end
    // pc holds through the flush slot, so a skip loads pc plus two up front, stepping over one word
    assign next_pc = !executing ? pc :
                     is_jump    ? jump_tgt :
                     is_ret     ? stack[sp_top] :
                     skip       ? pc_two :
                     pc_inc;
    // the word shown during the flush slot is dropped, then runs next cycle
    assign next_state = (executing && (is_jump || is_ret || skip)) ? MRID_FLUSH :
                        MRID_EXEC;

    // ========================================
    // registers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            porta_s1 <= 8'h00;
            porta_s2 <= 8'h00;
            portc_s1 <= 8'h00;
            portc_s2 <= 8'h00;
        end else begin
            porta_s1 <= i_porta_pins;
            porta_s2 <= porta_s1;
            portc_s1 <= i_portc_pins;
            portc_s2 <= portc_s1;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state  <= MRID_EXEC;
            pc     <= `MRID_PC_RESET;
            wreg   <= `MRID_W_RESET;
            status <= `MRID_ST_RESET;
            sp     <= '0;
        end else begin
            state  <= next_state;
            pc     <= next_pc;
            status <= next_status;
            if (wr_w)
                wreg <= alu_bus.res;
            if (op == mrid_pkg::MRID_CALL)
                sp <= sp + 1'b1;
            else if (is_ret)
                sp <= sp_top;
        end
    end

    // stack has no reset; overflow wraps silently over the oldest entry
    always_ff @(posedge i_clk) begin
        if (op == mrid_pkg::MRID_CALL)
            stack[sp] <= pc_inc;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wdt_pulse   <= 1'b0;
            sleep_pulse <= 1'b0;
            pre_pulse   <= 1'b0;
            o_gie_set   <= 1'b0;
        end else begin
            wdt_pulse   <= (sysop == mrid_pkg::MRID_SYS_WDT);
            sleep_pulse <= (sysop == mrid_pkg::MRID_SYS_SLEEP);
            pre_pulse   <= wr_file && faddr == `MRID_ADDR_TIMER_ZERO && i_psa_to_timer0;
            o_gie_set   <= (op == mrid_pkg::MRID_RETURN_FROM_IRQ);
        end
    end

    // ========================================
    // outputs
    assign o_pc            = pc;
    assign o_file_addr     = faddr;
    assign o_file_we       = wr_file && faddr != `MRID_ADDR_STATUS;
    assign o_file_wdata    = alu_bus.res;
    assign o_wreg          = wreg;
    assign o_status        = status;
    assign o_prescaler_clr = pre_pulse;
    assign o_watchdog_clr  = wdt_pulse;
    assign o_sleep         = sleep_pulse;

    // ========================================
    // checks
    a_skip_flush: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        executing && skip |=> state == MRID_FLUSH && o_file_we == 1'b0)
        else $error("true test did not insert flush cycle");
    a_jump_target: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        executing && is_jump |=> pc == $past(jump_tgt) ##1 state == MRID_EXEC)
        else $error("jump did not load target in two cycles");
    a_add_carry: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        op == mrid_pkg::MRID_ADD_WREG_TO_FILE |=>
        status[`MRID_ST_C] == (({1'b0, $past(file_src)} + {1'b0, $past(wreg)}) > 9'h0ff))
        else $error("add carry wrong");
    a_skip_flags: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        op inside {mrid_pkg::MRID_DECREMENT_SKIP_ZERO, mrid_pkg::MRID_INCREMENT_SKIP_ZERO}
        |=> $stable(status))
        else $error("skip-on-zero changed status");
    a_clear_work_reg_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        op == mrid_pkg::MRID_CLEAR_WORK_REG |=> wreg == 8'h00 && status[`MRID_ST_Z])
        else $error("clear of w did not set zero");
    a_swap_nib: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        op == mrid_pkg::MRID_SWAP_FILE_NIBBLES && !dest |=>
        wreg == {$past(file_src[3:0]), $past(file_src[7:4])} && $stable(status))
        else $error("swap result wrong");
    a_wdt_flags: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        sysop == mrid_pkg::MRID_SYS_WDT |=> status[4:3] == 2'b11 && o_watchdog_clr)
        else $error("watchdog kick flags wrong");
    a_tmr_presc: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_file_we && faddr == `MRID_ADDR_TIMER_ZERO && i_psa_to_timer0 |=> o_prescaler_clr)
        else $error("prescaler not cleared");
    a_ret_two: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        executing && is_ret |=> !executing ##1 executing)
        else $error("return not two cycles");
endmodule
`default_nettype wire

// file: verification/mrid_mem_model.sv
// program memory and data file space facing the decoder core
// assumes the bench preloads both arrays; reads are combinational
`default_nettype none
module mrid_mem_model (
    input  wire logic        i_clk,
    input  wire logic [12:0] i_pc,
    input  wire logic [6:0]  i_file_addr,
    input  wire logic        i_file_we,
    input  wire logic [7:0]  i_file_wdata,
    output logic      [13:0] o_insn,
    output logic      [7:0]  o_file_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // storage
    logic [13:0] prog [0:63];
    logic [7:0]  file [0:127];
    // past the loaded words every fetch is a no-operation
    assign o_insn       = (i_pc < 13'h0040) ? prog[i_pc[5:0]] : 14'h0000;
    assign o_file_rdata = file[i_file_addr];
    always @(posedge i_clk) begin
        if (i_file_we) begin
            file[i_file_addr] <= i_file_wdata;
        end
    end
endmodule
`default_nettype wire

// file: verification/test_mid_range_14bit_insn_decoder.sv
// self-checking bench for the instruction decoder core
// assumes mrid_mem_model supplies words and file data combinationally
`default_nettype none
module test_mid_range_14bit_insn_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // wiring
    logic        clk;
    logic        reset_n;
    logic        psa;
    logic [7:0]  porta;
    logic [7:0]  portc;
    logic [13:0] insn;
    logic [7:0]  rdata;
    logic [12:0] pc;
    logic [6:0]  faddr;
    logic        fwe;
    logic [7:0]  fwdata;
    logic [7:0]  wreg;
    logic [7:0]  status;
    logic        pclr;
    logic        wclr;
    logic        slp;
    logic        gie;
    logic [7:0]  n_gie;
    logic [7:0]  n_pclr;
    logic [7:0]  n_wclr;
    logic [7:0]  n_slp;
    int          n_fail;
    int          checks_done;
    mrid_core dut (.i_clk(clk), .i_reset_n(reset_n), .i_insn(insn), .i_file_rdata(rdata),
        .i_porta_pins(porta), .i_portc_pins(portc), .i_psa_to_timer0(psa),
        .i_pclath_hi(2'h0), .o_pc(pc), .o_file_addr(faddr), .o_file_we(fwe),
        .o_file_wdata(fwdata), .o_wreg(wreg), .o_status(status), .o_prescaler_clr(pclr),
        .o_watchdog_clr(wclr), .o_sleep(slp), .o_gie_set(gie));
    mrid_mem_model mem (.i_clk(clk), .i_pc(pc), .i_file_addr(faddr), .i_file_we(fwe),
        .i_file_wdata(fwdata), .o_insn(insn), .o_file_rdata(rdata));
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            n_pclr <= 8'h00;
            n_wclr <= 8'h00;
            n_slp  <= 8'h00;
            n_gie  <= 8'h00;
        end else begin
            n_pclr <= n_pclr + {7'h00, pclr};
            n_wclr <= n_wclr + {7'h00, wclr};
            n_slp  <= n_slp + {7'h00, slp};
            n_gie  <= n_gie + {7'h00, gie};
        end
    end
    // ==========================================
    // shared tasks
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // holds reset while it reloads the program, so the run starts at word zero
    task automatic run_prog(input logic [13:0] p [9]);
        @(negedge clk);
        reset_n = 1'b0;
        for (int i = 0; i < 9; i++) begin
            mem.prog[i] = p[i];
        end
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        repeat (30) @(negedge clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic test_arith();
        run_prog('{14'h30f8, 14'h3e08, 14'h385a, 14'h00a0, 14'h07a0, 14'h0e20, 14'h00a4,
            14'h0100, 0});
        chk8("wreg", 8'h00, wreg);
        chk8("file20", 8'hb4, mem.file[32]);
        chk8("file24", 8'h4b, mem.file[36]);
        chk8("status", 8'h1e, status);
        $display("test arith done");
    endtask
    task automatic test_skip();
        run_prog('{14'h3001, 14'h00a1, 14'h0ba1, 14'h30ee, 14'h1c21, 14'h3033, 14'h1821,
            14'h3044, 0});
        chk8("wreg", 8'h33, wreg);
        chk8("file21", 8'h00, mem.file[33]);
        chk8("status", 8'h18, status);
        $display("test skip done");
    endtask
    // pins differ from the stored latch so a latch read shows up
    task automatic test_ctrl();
        run_prog('{14'h0064, 14'h3007, 14'h0081, 14'h2806, 14'h3099, 14'h3099, 14'h0805,
            14'h1487, 14'h0063});
        chk8("wreg", 8'ha5, wreg);
        chk8("file07", 8'h32, mem.file[7]);
        chk8("status", 8'h10, status);
        chk8("wdt pulses", 8'h01, n_wclr);
        chk8("sleep pulses", 8'h01, n_slp);
        chk8("prescaler pulses", 8'h01, n_pclr);
        $display("test ctrl done");
    endtask
    // two calls in turn, each returned from before the next, then a subtract into the file; word 4 parks the core
    task automatic test_calls();
        run_prog('{14'h2005, 14'h2007, 14'h00a2, 14'h02a2, 14'h2804, 14'h3403, 0, 14'h0009,
            0});
        chk8("wreg", 8'h03, wreg);
        chk8("file22", 8'h00, mem.file[34]);
        chk8("status", 8'h1f, status);
        chk8("irq return pulses", 8'h01, n_gie);
        $display("test calls done");
    endtask
    // ==========================================
    // clock, sequence, watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        reset_n     = 1'b0;
        psa         = 1'b1;
        porta       = 8'ha5;
        portc       = 8'h30;
        n_fail      = 0;
        checks_done = 0;
        for (int i = 0; i < 64; i++) begin
            mem.prog[i] = 14'h0000;
        end
        for (int i = 0; i < 128; i++) begin
            mem.file[i] = 8'h00;
        end
        mem.file[5] = 8'h5a;
        test_arith();
        test_skip();
        test_ctrl();
        test_calls();
        print_verdict();
    end
    // four runs of about forty cycles each; far beyond that means a hang
    initial begin
        #20000;
        n_fail++;
        print_verdict();
    end
endmodule
`default_nettype wire
